// ==== hw/regulator_ctrl_pkg.sv ====
package regulator_ctrl_pkg;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAILSAFE
  } chip_mode_t;

  typedef enum logic [1:0] {
    CFG_NONE,
    CFG_STANDALONE,
    CFG_LOADSHARE
  } ext_cfg_t;

  // host-written control bits, sampled on the write strobe
  typedef struct packed {
    logic second_regulator_enable;
    logic standalone_enable_bit;
    logic load_share_enable_bit;
    logic voltage_select_bit;
    logic keep_on_at_low_supply_bit;
    logic load_share_stop_keep_bit;
  } host_ctrl_t;

  // analog comparator indications
  typedef struct packed {
    logic second_load_high;
    logic second_load_low;
    logic ext_base_high;
    logic ext_base_low;
    logic supply_undervoltage;
    logic main_regulator_on;
  } analog_ind_t;

  typedef struct packed {
    logic second_lp_en;
    logic second_hp_en;
    logic ext_lp_en;
    logic ext_hp_en;
    logic ext_sel_3v3;
  } stage_en_t;

  typedef struct packed {
    logic ext_on;
    logic ext_standalone;
    logic ext_loadshare;
    logic ext_cfg_locked;
    logic ext_uv_off;
  } supply_status_t;

  localparam logic RST_SECOND_ON = 1'b0;
  localparam logic RST_EXT_ON = 1'b0;
  localparam logic RST_HP_STAGE = 1'b0;
  localparam logic RST_VSEL = 1'b0;
  localparam ext_cfg_t RST_EXT_CFG = CFG_NONE;

endpackage : regulator_ctrl_pkg

// ==== hw/regulator_mode_enable_control.sv ====
`timescale 1ns/1ps
// Functional notes
// - in normal mode the second regulator follows the host enable bit
// - second regulator state is frozen during stop and sleep modes
// - stop mode: second low-power stage alone, high stage added on high load
// - normal mode: both second regulator stages enabled
// - stop mode: external low stage, high stage added on high base current
// - normal mode: only external high-power stage enabled
// - standalone bit set in normal mode selects standalone configuration
// - load-share bit selects load sharing with the main regulator
// - first configuration set locks it; later changes ignored
// - lock survives soft reset, cleared only by power removal
// - standalone: voltage select 0 gives 5.0V, 1 gives 3.3V
// - voltage select ignored in load sharing
// - undervoltage turns external off unless keep-on bit set; auto back on when it clears
// - keep-on bit holds external regulator on during undervoltage
// - load sharing with stop-keep bit keeps external active in stop
// - standalone: off in init/failsafe, host in normal, held elsewhere
// - load sharing follows main regulator per chip mode
// - external regulator status flags are reported to the host
// - change attempt after load-share lock raises spi error
// - change attempt after standalone lock leaves spi error alone
// - load share resumes in normal after automatic stop-mode disable
module regulator_mode_enable_control (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic clk_en_in,
  input wire regulator_ctrl_pkg::chip_mode_t mode_in,
  input wire logic ctrl_wr_in,
  input wire regulator_ctrl_pkg::host_ctrl_t ctrl_in,
  input wire regulator_ctrl_pkg::analog_ind_t ind_in,
  output regulator_ctrl_pkg::stage_en_t stage_out,
  output regulator_ctrl_pkg::supply_status_t status_out,
  output logic spi_error_out
);
  import regulator_ctrl_pkg::*;

  ext_cfg_t cfg_ff;
  logic second_on_ff;
  logic second_hp_ff;
  logic ext_host_on_ff;
  logic ext_hp_ff;
  logic vsel_ff;
  logic keep_uv_ff;
  logic ls_stop_keep_ff;
  logic spi_error_ff;
  logic ext_hold_ff;
  logic ext_en;
  logic cfg_locked;
  logic cfg_change;
  logic nxt_ext_hold;

  assign cfg_locked = (cfg_ff != CFG_NONE);
  assign cfg_change = ctrl_wr_in && cfg_locked &&
    ((ctrl_in.load_share_enable_bit != (cfg_ff == CFG_LOADSHARE)) ||
     (ctrl_in.standalone_enable_bit && cfg_ff == CFG_LOADSHARE));

  // lock is power-on only so a soft reset cannot reopen the choice
  always_ff @(posedge clk_sys_in) begin
    if (por_in) begin
      cfg_ff <= RST_EXT_CFG;
    end else if (clk_en_in && ctrl_wr_in && !cfg_locked) begin
      if (ctrl_in.load_share_enable_bit) begin
        cfg_ff <= CFG_LOADSHARE;
      end else if (ctrl_in.standalone_enable_bit && mode_in == MODE_NORMAL) begin
        cfg_ff <= CFG_STANDALONE;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || por_in) begin
      spi_error_ff <= 1'b0;
    end else if (clk_en_in && ctrl_wr_in) begin
      // change attempts in standalone lock leave the flag alone
      if (cfg_change && cfg_ff == CFG_LOADSHARE) begin
        spi_error_ff <= 1'b1;
      end else if (!cfg_change) begin
        spi_error_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || por_in) begin
      second_on_ff <= RST_SECOND_ON;
      ext_host_on_ff <= RST_EXT_ON;
      vsel_ff <= RST_VSEL;
      keep_uv_ff <= 1'b0;
      ls_stop_keep_ff <= 1'b0;
    end else if (clk_en_in && ctrl_wr_in) begin
      if (mode_in == MODE_NORMAL) begin
        second_on_ff <= ctrl_in.second_regulator_enable;
        ext_host_on_ff <= ctrl_in.standalone_enable_bit;
      end
      vsel_ff <= ctrl_in.voltage_select_bit;
      keep_uv_ff <= ctrl_in.keep_on_at_low_supply_bit;
      ls_stop_keep_ff <= ctrl_in.load_share_stop_keep_bit;
    end
  end

  // high-power stage handover on threshold indications in stop mode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || por_in) begin
      second_hp_ff <= RST_HP_STAGE;
      ext_hp_ff <= RST_HP_STAGE;
    end else if (clk_en_in) begin
      if (mode_in != MODE_STOP) begin
        second_hp_ff <= 1'b0;
        ext_hp_ff <= 1'b0;
      end else begin
        if (ind_in.second_load_high) begin
          second_hp_ff <= 1'b1;
        end else if (ind_in.second_load_low) begin
          second_hp_ff <= 1'b0;
        end
        if (ind_in.ext_base_high) begin
          ext_hp_ff <= 1'b1;
        end else if (ind_in.ext_base_low) begin
          ext_hp_ff <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    nxt_ext_hold = ext_hold_ff;
    unique case (mode_in)
      MODE_INIT, MODE_FAILSAFE: nxt_ext_hold = 1'b0;
      MODE_NORMAL: nxt_ext_hold = ext_host_on_ff;
      MODE_STOP, MODE_SLEEP, MODE_RESTART: nxt_ext_hold = ext_hold_ff;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || por_in) begin
      ext_hold_ff <= RST_EXT_ON;
    end else if (clk_en_in) begin
      ext_hold_ff <= nxt_ext_hold;
    end
  end

  always_comb begin
    ext_en = 1'b0;
    if (cfg_ff == CFG_STANDALONE) begin
      ext_en = nxt_ext_hold;
    end else if (cfg_ff == CFG_LOADSHARE) begin
      unique case (mode_in)
        MODE_NORMAL, MODE_RESTART: ext_en = ind_in.main_regulator_on;
        MODE_STOP: ext_en = ls_stop_keep_ff && ind_in.main_regulator_on;
        MODE_INIT, MODE_SLEEP, MODE_FAILSAFE: ext_en = 1'b0;
      endcase
    end
    if (ind_in.supply_undervoltage && !keep_uv_ff) begin
      ext_en = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || por_in) begin
      stage_out <= '0;
      status_out <= '0;
    end else if (clk_en_in) begin
      stage_out.second_lp_en <= second_on_ff;
      stage_out.second_hp_en <= second_on_ff &&
        (mode_in == MODE_NORMAL || second_hp_ff);
      stage_out.ext_lp_en <= ext_en && mode_in != MODE_NORMAL;
      stage_out.ext_hp_en <= ext_en && (mode_in != MODE_STOP || ext_hp_ff);
      stage_out.ext_sel_3v3 <= (cfg_ff == CFG_STANDALONE) && vsel_ff;
      status_out.ext_on <= ext_en;
      status_out.ext_standalone <= cfg_ff == CFG_STANDALONE;
      status_out.ext_loadshare <= cfg_ff == CFG_LOADSHARE;
      status_out.ext_cfg_locked <= cfg_locked;
      status_out.ext_uv_off <= ind_in.supply_undervoltage && !keep_uv_ff;
    end
  end

  assign spi_error_out = spi_error_ff;

  // a threshold step only reaches the stage outputs two edges later
  sequence seq_stop_cycle;
    clk_en_in && mode_in == MODE_STOP;
  endsequence

  sequence seq_second_rise;
    clk_en_in && mode_in == MODE_STOP && ind_in.second_load_high;
  endsequence

  sequence seq_second_fall;
    clk_en_in && mode_in == MODE_STOP && !ind_in.second_load_high && ind_in.second_load_low;
  endsequence

  sequence seq_base_rise;
    clk_en_in && mode_in == MODE_STOP && ind_in.ext_base_high;
  endsequence

  sequence seq_base_fall;
    clk_en_in && mode_in == MODE_STOP && !ind_in.ext_base_high && ind_in.ext_base_low;
  endsequence

  chk_lock_sticky: assert property (
    @(posedge clk_sys_in) disable iff (por_in)
    cfg_locked |=> cfg_locked && $stable(cfg_ff))
    else $error("configuration lock changed");

  chk_uv_shutoff: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && ind_in.supply_undervoltage && !keep_uv_ff |=> !status_out.ext_on)
    else $error("external on during undervoltage");

  chk_ls_error: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_change && cfg_ff == CFG_LOADSHARE |=> spi_error_out)
    else $error("spi error not raised");

  chk_sa_noerror: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_change && cfg_ff == CFG_STANDALONE |=> $stable(spi_error_out))
    else $error("spi error touched");

  chk_normal_stages: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && mode_in == MODE_NORMAL |=> !stage_out.ext_lp_en)
    else $error("external low stage in normal");

  chk_second_both: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && mode_in == MODE_NORMAL && second_on_ff |=>
      stage_out.second_hp_en && stage_out.second_lp_en)
    else $error("second stages not both on");

  chk_vsel_ls: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_ff == CFG_LOADSHARE |=> !stage_out.ext_sel_3v3)
    else $error("voltage select used in load sharing");

  chk_second_hold: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    mode_in == MODE_STOP || mode_in == MODE_SLEEP |=> $stable(second_on_ff))
    else $error("second regulator changed in low power");

  chk_failsafe_off: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && (mode_in == MODE_FAILSAFE || mode_in == MODE_INIT) |=>
      !status_out.ext_on)
    else $error("external on in init or failsafe");

  chk_second_hp_rise: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    seq_second_rise ##1 seq_stop_cycle |=> stage_out.second_hp_en == second_on_ff)
    else $error("second high stage not added");

  chk_second_hp_fall: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    seq_second_fall ##1 seq_stop_cycle |=> !stage_out.second_hp_en)
    else $error("second high stage not removed");

  chk_base_hp_rise: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    seq_base_rise ##1 seq_stop_cycle |=> stage_out.ext_hp_en == status_out.ext_on)
    else $error("external high stage not added");

  chk_base_hp_fall: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    seq_base_fall ##1 seq_stop_cycle |=> !stage_out.ext_hp_en)
    else $error("external high stage not removed");

  chk_stop_low_stage: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    seq_stop_cycle |=> stage_out.ext_lp_en == status_out.ext_on)
    else $error("external low stage wrong in stop");

  chk_second_follow: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && ctrl_wr_in && mode_in == MODE_NORMAL ##1 clk_en_in |=>
      stage_out.second_lp_en == $past(ctrl_in.second_regulator_enable, 2))
    else $error("second regulator ignores host enable");

  chk_standalone_pick: assert property (
    @(posedge clk_sys_in) disable iff (por_in)
    clk_en_in && ctrl_wr_in && !cfg_locked && mode_in == MODE_NORMAL &&
      ctrl_in.standalone_enable_bit && !ctrl_in.load_share_enable_bit |=>
      cfg_ff == CFG_STANDALONE)
    else $error("standalone configuration not taken");

  chk_loadshare_pick: assert property (
    @(posedge clk_sys_in) disable iff (por_in)
    clk_en_in && ctrl_wr_in && !cfg_locked && ctrl_in.load_share_enable_bit |=>
      cfg_ff == CFG_LOADSHARE)
    else $error("load sharing configuration not taken");

  chk_por_unlock: assert property (
    @(posedge clk_sys_in)
    por_in |=> !cfg_locked)
    else $error("lock survives power-on reset");

  chk_soft_keep: assert property (
    @(posedge clk_sys_in) disable iff (por_in)
    rst_in && cfg_locked |=> cfg_ff == $past(cfg_ff))
    else $error("soft reset changed configuration");

  chk_uv_keep: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && ind_in.supply_undervoltage && keep_uv_ff && cfg_ff == CFG_STANDALONE &&
      mode_in == MODE_NORMAL |=> status_out.ext_on == $past(ext_host_on_ff))
    else $error("keep-on bit not honoured");

  chk_ls_stop_keep: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_ff == CFG_LOADSHARE && mode_in == MODE_STOP && ls_stop_keep_ff &&
      ind_in.main_regulator_on && !ind_in.supply_undervoltage |=> status_out.ext_on)
    else $error("load sharing dropped in stop");

  chk_ls_off_modes: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_ff == CFG_LOADSHARE &&
      (mode_in == MODE_INIT || mode_in == MODE_SLEEP || mode_in == MODE_FAILSAFE) |=>
      !status_out.ext_on)
    else $error("load sharing on in off mode");

  chk_sel_standalone: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_ff == CFG_STANDALONE |=> stage_out.ext_sel_3v3 == $past(vsel_ff))
    else $error("voltage select not applied");

  chk_hold_low_power: assert property (
    @(posedge clk_sys_in) disable iff (rst_in || por_in)
    clk_en_in && cfg_ff == CFG_STANDALONE && !ind_in.supply_undervoltage &&
      (mode_in == MODE_STOP || mode_in == MODE_SLEEP || mode_in == MODE_RESTART) |=>
      status_out.ext_on == $past(ext_hold_ff))
    else $error("external state not held");

endmodule : regulator_mode_enable_control

// ==== verif/host_spi_model.sv ====
`timescale 1ns/1ps
module host_spi_model (
  input wire logic clk_sys_in,
  output logic ctrl_wr_out,
  output regulator_ctrl_pkg::host_ctrl_t ctrl_out
);
  import regulator_ctrl_pkg::*;
  initial begin
    ctrl_wr_out = 1'b0;
    ctrl_out = '0;
  end
  // one-cycle strobe; data is scrambled afterwards so a late sample shows up
  task automatic write(input host_ctrl_t val);
    @(negedge clk_sys_in);
    ctrl_out = val;
    ctrl_wr_out = 1'b1;
    @(negedge clk_sys_in);
    ctrl_wr_out = 1'b0;
    ctrl_out = ~val;
  endtask : write
endmodule : host_spi_model

// ==== verif/regulator_mode_enable_control_bench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module regulator_mode_enable_control_bench;
  import regulator_ctrl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  chip_mode_t mode = MODE_INIT;
  analog_ind_t ind = 6'h01;
  logic clk_en = 1'b1;
  logic wr;
  host_ctrl_t ctrl;
  stage_en_t stg;
  supply_status_t st;
  logic err;
  logic prev_on;
  chip_mode_t m;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  regulator_mode_enable_control regulator_mode_enable_control_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in), .clk_en_in(clk_en),
    .mode_in(mode), .ctrl_wr_in(wr), .ctrl_in(ctrl), .ind_in(ind),
    .stage_out(stg), .status_out(st), .spi_error_out(err));
  host_spi_model host_spi_model_inst (.clk_sys_in(clk_sys_in), .ctrl_wr_out(wr),
    .ctrl_out(ctrl));
  task automatic settle();
    repeat (3) @(negedge clk_sys_in);
  endtask : settle
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // off in init and fail-safe, on in normal, held elsewhere
  function automatic logic exp_on(chip_mode_t md, logic prev);
    if (md == MODE_INIT || md == MODE_FAILSAFE) return 1'b0;
    return (md == MODE_NORMAL) ? 1'b1 : prev;
  endfunction : exp_on
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    void'($urandom(35));
    repeat (8) @(negedge clk_sys_in);
    `CHK(st, 5'h00)
    rst_in = 1'b0;
    por_in = 1'b0;
    mode = MODE_NORMAL;
    host_spi_model_inst.write(6'h2C);
    settle();
    `CHK(st.ext_loadshare, 1'b1)
    `CHK(st.ext_cfg_locked, 1'b1)
    `CHK(stg, 5'h1A)
    `CHK(st.ext_on, 1'b1)
    host_spi_model_inst.write(6'h24);
    settle();
    `CHK(err, 1'b1)
    `CHK(st.ext_loadshare, 1'b1)
    mode = MODE_STOP;
    settle();
    `CHK(st.ext_on, 1'b0)
    mode = MODE_NORMAL;
    settle();
    `CHK(st.ext_on, 1'b1)
    host_spi_model_inst.write(6'h2D);
    mode = MODE_STOP;
    settle();
    `CHK(st.ext_on, 1'b1)
    mode = MODE_NORMAL;
    ind = 6'h00;
    settle();
    `CHK(st.ext_on, 1'b0)
    ind = 6'h01;
    mode = MODE_RESTART;
    settle();
    `CHK(st.ext_on, 1'b1)
    mode = MODE_SLEEP;
    settle();
    `CHK(st.ext_on, 1'b0)
    mode = MODE_NORMAL;
    rst_in = 1'b1;
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    settle();
    `CHK(st.ext_cfg_locked, 1'b1)
    `CHK(st.ext_loadshare, 1'b1)
    done("loadshare_lock");
    por_in = 1'b1;
    @(negedge clk_sys_in);
    por_in = 1'b0;
    host_spi_model_inst.write(6'h34);
    settle();
    `CHK(st.ext_standalone, 1'b1)
    `CHK(stg.ext_sel_3v3, 1'b1)
    host_spi_model_inst.write(6'h3C);
    settle();
    `CHK(err, 1'b0)
    `CHK(st.ext_loadshare, 1'b0)
    mode = MODE_STOP;
    settle();
    `CHK(stg, 5'h15)
    ind = 6'h09;
    settle();
    `CHK(stg.ext_hp_en, 1'b1)
    ind = 6'h05;
    settle();
    `CHK(stg.ext_hp_en, 1'b0)
    ind = 6'h21;
    settle();
    `CHK(stg.second_hp_en, 1'b1)
    ind = 6'h11;
    settle();
    `CHK(stg.second_hp_en, 1'b0)
    ind = 6'h01;
    host_spi_model_inst.write(6'h14);
    settle();
    `CHK(stg.second_lp_en, 1'b1)
    done("standalone_stop");
    mode = MODE_NORMAL;
    host_spi_model_inst.write(6'h34);
    ind = 6'h03;
    settle();
    `CHK(st.ext_on, 1'b0)
    `CHK(st.ext_uv_off, 1'b1)
    ind = 6'h01;
    settle();
    `CHK(st.ext_on, 1'b1)
    host_spi_model_inst.write(6'h36);
    ind = 6'h03;
    settle();
    `CHK(st.ext_on, 1'b1)
    `CHK(st.ext_uv_off, 1'b0)
    ind = 6'h01;
    clk_en = 1'b0;
    mode = MODE_FAILSAFE;
    settle();
    `CHK(st.ext_on, 1'b1)
    clk_en = 1'b1;
    settle();
    `CHK(st.ext_on, 1'b0)
    done("undervoltage");
    prev_on = 1'b0;
    repeat (16) begin
      m = chip_mode_t'(3'($urandom_range(5, 0)));
      mode = m;
      settle();
      prev_on = exp_on(m, prev_on);
      `CHK(st.ext_on, prev_on)
    end
    done("random_modes");
    results();
  end
endmodule : regulator_mode_enable_control_bench
